// ---- vnip_core_model.sv ----
`timescale 1ns/10ps
module vnip_core_model (
  input  wire logic        clk_in,
  input  wire logic [31:0] rdata_in,
  input  wire logic        wait_in,
  input  wire logic        normal_req_in,
  output logic      [31:0] addr_out,
  output logic             rd_out,
  output logic             wr_out,
  output logic      [3:0]  be_out,
  output logic      [31:0] wdata_out
);
  logic nest_q;
  initial begin
    addr_out = 32'h0;
    rd_out = 1'b0;
    wr_out = 1'b0;
    be_out = 4'hf;
    wdata_out = 32'h0;
    nest_q = 1'b0;
  end
  // Hold until waitrequest low, then release and scramble idle lines
  task automatic finish_req(output logic [31:0] d);
    @(posedge clk_in);
    while (wait_in !== 1'b0) @(posedge clk_in);
    d = rdata_in;
    rd_out <= 1'b0;
    wr_out <= 1'b0;
    addr_out <= ~addr_out;
    wdata_out <= ~wdata_out;
    @(posedge clk_in);
  endtask
  task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
    addr_out <= a;
    rd_out <= 1'b1;
    finish_req(d);
  endtask
  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] unused;
    addr_out <= a;
    wr_out <= 1'b1;
    wdata_out <= (a == vnip_pkg::ADDR_NESTING_CONTROL) ? (d & 32'h0000_0003) : d;
    if (a == vnip_pkg::ADDR_NESTING_CONTROL) nest_q = d[0];
    finish_req(unused);
  endtask
  // Vector fetched only when a normal request is taken with nesting on
  task automatic take_irq(output logic [31:0] v);
    v = 32'hffff_ffff;
    if (normal_req_in === 1'b1 && nest_q) bus_rd(vnip_pkg::ADDR_IRQ_VECTOR, v);
  endtask
endmodule

// ---- vnip_irq_priority.sv ----
`timescale 1ns/10ps
module vnip_irq_priority #(
  parameter int NUM_SRC = vnip_pkg::NUM_SRC
) (
  input  wire logic               ref_clk_in,
  input  wire logic               rst_n_in,
  input  wire logic [31:0]        avs_address_in,
  input  wire logic               avs_read_in,
  input  wire logic               avs_write_in,
  input  wire logic [3:0]         avs_byteenable_in,
  input  wire logic [31:0]        avs_writedata_in,
  output logic      [31:0]        avs_readdata_out,
  output logic                    avs_waitrequest_out,
  input  wire logic [NUM_SRC-1:0] normal_src_in,
  input  wire logic [NUM_SRC-1:0] fast_src_in,
  output logic                    normal_req_out,
  output logic                    fast_req_out,
  output logic [vnip_pkg::SRC_W-1:0] fast_source_out,
  output logic                    event_irq_out
);

  // Reset release synchroniser
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // Index of lowest set bit (highest priority), NUM_LEVEL when none
  function automatic logic [3:0] first_set(input logic [vnip_pkg::NUM_LEVEL-1:0] v);
    logic [3:0] r;
    r = 4'(vnip_pkg::NUM_LEVEL);
    for (int i = vnip_pkg::NUM_LEVEL - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // Choose the winning source; ties go to the lowest number
  function automatic vnip_pkg::vnip_pick_t pick(
    input logic [NUM_SRC-1:0]                act,
    input logic [vnip_pkg::PRIO_REGS*32-1:0] prio,
    input logic                              use_prio,
    input logic [3:0]                        limit
  );
    vnip_pkg::vnip_pick_t         p;
    logic [vnip_pkg::LEVEL_W-1:0] lvl;
    p = '0;
    lvl = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      lvl = use_prio ? prio[s*vnip_pkg::FIELD_PITCH +: vnip_pkg::LEVEL_W] : '0;
      if (act[s] && ({1'b0, lvl} < limit) && (!p.found || (lvl < p.level))) begin
        p.found = 1'b1;
        p.num   = s[vnip_pkg::SRC_W-1:0];
        p.level = lvl;
      end
    end
    return p;
  endfunction

  // Byte-enable merge of a write into a stored word
  function automatic logic [31:0] merge_be(input logic [31:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Register state
  logic [vnip_pkg::PRIO_REGS*32-1:0]  prio_q;
  logic [vnip_pkg::NEST_W-1:0]        nest_q;
  logic [vnip_pkg::BASE_W-1:0]        base_q;
  logic [vnip_pkg::NUM_LEVEL-1:0]     in_service_q;
  logic [vnip_pkg::EV_W-1:0]          ev_status_q;
  logic [vnip_pkg::EV_W-1:0]          ev_enable_q;
  vnip_pkg::vnip_pick_t               normal_pick_q;
  vnip_pkg::vnip_pick_t               fast_pick_q;
  logic                               normal_req_q;
  logic                               fast_req_q;
  logic                               wait_q;
  logic [31:0]                        rdata_q;
  logic                               irq_q;

  // Bus decode
  logic        accept;
  logic        wr_acc;
  logic        rd_acc;
  logic [31:0] wmerge_d;
  logic [31:0] rdata_d;
  logic [31:0] vector_word;
  logic [3:0]  prio_sel;
  logic        prio_hit;

  assign accept = (avs_read_in || avs_write_in) && wait_q;
  assign wr_acc = accept && avs_write_in;
  assign rd_acc = accept && avs_read_in;

  always_comb begin
    prio_hit = 1'b1;
    prio_sel = 4'h0;
    unique case (avs_address_in)
      vnip_pkg::ADDR_PRIO_TIMERS:   prio_sel = 4'h1;
      vnip_pkg::ADDR_PRIO_SERIAL:   prio_sel = 4'h2;
      vnip_pkg::ADDR_PRIO_EXTERNAL: prio_sel = 4'h4;
      vnip_pkg::ADDR_PRIO_PWM:      prio_sel = 4'h8;
      default:                      prio_hit = 1'b0;
    endcase
  end

  // Vector word assembled from the latched winner and the base
  always_comb begin
    vector_word = vnip_pkg::RST_WORD;
    vector_word[vnip_pkg::VEC_BASE_LSB +: vnip_pkg::BASE_W] = base_q;
    vector_word[vnip_pkg::VEC_SRC_LSB +: vnip_pkg::SRC_W] = normal_pick_q.num;
  end

  // Priority fields, reserved bits held at zero
  localparam logic [vnip_pkg::PRIO_REGS*32-1:0] PRIO_MASK = {
    vnip_pkg::PRIO_MASK_PWM,
    vnip_pkg::PRIO_MASK_EXTERNAL,
    vnip_pkg::PRIO_MASK_SERIAL,
    vnip_pkg::PRIO_MASK_TIMERS
  };

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      prio_q <= '0;
    end else begin
      for (int r = 0; r < vnip_pkg::PRIO_REGS; r++) begin
        if (wr_acc && prio_sel[r]) begin
          prio_q[r*32 +: 32] <= merge_be(prio_q[r*32 +: 32], avs_writedata_in,
                                         avs_byteenable_in)
                                & PRIO_MASK[r*32 +: 32];
        end
      end
    end
  end

  // Nesting control: only the two active bits are stored
  assign wmerge_d = merge_be(32'(nest_q), avs_writedata_in, avs_byteenable_in);

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      nest_q <= '0;
    end else if (wr_acc && avs_address_in == vnip_pkg::ADDR_NESTING_CONTROL) begin
      nest_q <= wmerge_d[vnip_pkg::NEST_W-1:0];
    end
  end

  // Vector base, untouched by reads of the vector
  logic [31:0] base_merge;

  assign base_merge = merge_be(32'(base_q), avs_writedata_in, avs_byteenable_in);

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      base_q <= '0;
    end else if (wr_acc && avs_address_in == vnip_pkg::ADDR_VECTOR_BASE) begin
      base_q <= base_merge[vnip_pkg::BASE_W-1:0];
    end
  end

  // In-service tracking for the normal path
  logic [3:0] serve_top;
  logic       serve_set;
  logic       serve_clr;

  assign serve_top = first_set(in_service_q);
  assign serve_set = rd_acc && (avs_address_in == vnip_pkg::ADDR_IRQ_VECTOR)
                     && nest_q[vnip_pkg::NEST_NORMAL_BIT] && normal_pick_q.found;
  assign serve_clr = wr_acc && (avs_address_in == vnip_pkg::ADDR_NORMAL_IN_SERVICE)
                     && (serve_top < 4'(vnip_pkg::NUM_LEVEL))
                     && avs_writedata_in[serve_top[2:0]];

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      in_service_q <= vnip_pkg::RST_BYTE;
    end else begin
      if (serve_clr) begin
        in_service_q[serve_top[2:0]] <= 1'b0;
      end
      if (serve_set) begin
        in_service_q[normal_pick_q.level] <= 1'b1;
      end
    end
  end

  // Winner selection for both paths
  vnip_pkg::vnip_pick_t normal_pick_d;
  vnip_pkg::vnip_pick_t fast_pick_d;
  logic [3:0]           normal_limit;

  always_comb begin
    normal_limit = nest_q[vnip_pkg::NEST_NORMAL_BIT] ? serve_top
                                                     : 4'(vnip_pkg::NUM_LEVEL);
    normal_pick_d = pick(normal_src_in, prio_q,
                         nest_q[vnip_pkg::NEST_NORMAL_BIT],
                         normal_limit);
    fast_pick_d = pick(fast_src_in, prio_q,
                       nest_q[vnip_pkg::NEST_FAST_BIT],
                       4'(vnip_pkg::NUM_LEVEL));
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      normal_pick_q <= '0;
      fast_pick_q   <= '0;
    end else begin
      normal_pick_q <= normal_pick_d;
      fast_pick_q   <= fast_pick_d;
    end
  end

  // Requests to the core; fast always takes precedence
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      normal_req_q <= 1'b0;
      fast_req_q   <= 1'b0;
    end else begin
      fast_req_q   <= fast_pick_d.found;
      normal_req_q <= normal_pick_d.found && !fast_pick_d.found;
    end
  end

  // Sticky event status, set wins over clear
  logic [vnip_pkg::EV_W-1:0] ev_set;
  logic [vnip_pkg::EV_W-1:0] ev_clr;

  always_comb begin
    ev_set = '0;
    ev_set[vnip_pkg::EV_NORMAL_BIT] = normal_pick_d.found && !fast_pick_d.found && !normal_req_q;
    ev_set[vnip_pkg::EV_FAST_BIT]   = fast_pick_d.found && !fast_req_q;
    ev_clr = '0;
    if (wr_acc && avs_address_in == vnip_pkg::ADDR_EVENT_CLEAR) begin
      ev_clr = avs_writedata_in[vnip_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ev_status_q <= '0;
    end else begin
      ev_status_q <= (ev_status_q & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ev_enable_q <= '0;
    end else if (wr_acc && avs_address_in == vnip_pkg::ADDR_EVENT_ENABLE) begin
      ev_enable_q <= avs_writedata_in[vnip_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((ev_status_q & ~ev_clr) | ev_set) & ev_enable_q);
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = vnip_pkg::RST_WORD;
    if (prio_hit) begin
      for (int r = 0; r < vnip_pkg::PRIO_REGS; r++) begin
        if (prio_sel[r]) begin
          rdata_d = prio_q[r*32 +: 32];
        end
      end
    end else begin
      unique case (avs_address_in)
        vnip_pkg::ADDR_IRQ_VECTOR:        rdata_d = vector_word;
        vnip_pkg::ADDR_NESTING_CONTROL:   rdata_d = 32'(nest_q);
        vnip_pkg::ADDR_NORMAL_IN_SERVICE: rdata_d = 32'(in_service_q);
        vnip_pkg::ADDR_VECTOR_BASE:       rdata_d = 32'(base_q);
        vnip_pkg::ADDR_EVENT_STATUS:      rdata_d = 32'(ev_status_q);
        vnip_pkg::ADDR_EVENT_ENABLE:      rdata_d = 32'(ev_enable_q);
        default:                          rdata_d = vnip_pkg::RST_WORD;
      endcase
    end
  end

  // One wait cycle per access: accept, then release waitrequest
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wait_q  <= 1'b1;
      rdata_q <= vnip_pkg::RST_WORD;
    end else begin
      if (accept) begin
        wait_q <= 1'b0;
        if (avs_read_in) begin
          rdata_q <= rdata_d;
        end
      end else begin
        wait_q <= 1'b1;
      end
    end
  end

  assign avs_readdata_out    = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign normal_req_out      = normal_req_q;
  assign fast_req_out        = fast_req_q;
  assign fast_source_out     = fast_pick_q.num;
  assign event_irq_out       = irq_q;

endmodule

// ---- vnip_irq_priority_bench.sv ----
`timescale 1ns/10ps
module vnip_irq_priority_bench;
  logic        clk, rst_n, rd, wr, nreq, freq, eirq, wt;
  logic [31:0] addr, wdata, rdata, d;
  logic [3:0]  be;
  logic [27:0] nsrc, fsrc;
  logic [4:0]  fsn;
  int          errors, samples_checked;
  vnip_irq_priority i_vnip_irq_priority (.ref_clk_in(clk), .rst_n_in(rst_n),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_byteenable_in(be),
    .avs_writedata_in(wdata), .avs_readdata_out(rdata), .avs_waitrequest_out(wt),
    .normal_src_in(nsrc), .fast_src_in(fsrc), .normal_req_out(nreq), .fast_req_out(freq),
    .fast_source_out(fsn), .event_irq_out(eirq));
  vnip_core_model i_vnip_core_model (.clk_in(clk), .rdata_in(rdata), .wait_in(wt),
    .normal_req_in(nreq), .addr_out(addr), .rd_out(rd), .wr_out(wr), .be_out(be),
    .wdata_out(wdata));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wrc(input logic [31:0] a, input logic [31:0] w, input logic [31:0] exp);
    i_vnip_core_model.bus_wr(a, w);
    i_vnip_core_model.bus_rd(a, d);
    check(d, exp);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 13; i++) begin
      i_vnip_core_model.bus_rd(32'hffff_001c + 32'(4 * i), d);
      check(d, 32'h0000_0000);
    end
    $display("reset values done");
  endtask
  task automatic t_masks;
    wrc(32'hffff_0020, 32'hffff_ffff, 32'h7777_7770);
    wrc(32'hffff_0024, 32'hffff_ffff, 32'h7777_7777);
    wrc(32'hffff_0028, 32'hffff_ffff, 32'h7777_7777);
    wrc(32'hffff_002c, 32'hffff_ffff, 32'h0000_0077);
    wrc(32'hffff_001c, 32'hffff_ffff, 32'h0000_0000);
    wrc(32'hffff_0030, 32'h0000_0003, 32'h0000_0003);
    wrc(32'hffff_0030, 32'h0000_0000, 32'h0000_0000);
    $display("priority fields done");
  endtask
  task automatic t_plain;
    wrc(32'hffff_0040, 32'h0000_1234, 32'h0000_1234);
    nsrc <= 28'h000_0210;
    tick(2);
    check({31'h0, nreq}, 32'h1);
    i_vnip_core_model.bus_rd(32'hffff_001c, d);
    check(d, 32'h0009_1a10);
    i_vnip_core_model.bus_rd(32'hffff_001c, d);
    check(d, 32'h0009_1a10);
    i_vnip_core_model.bus_rd(32'hffff_003c, d);
    check(d, 32'h0000_0000);
    fsrc <= 28'h000_1080;
    tick(2);
    check({30'h0, freq, nreq}, 32'h2);
    check({27'h0, fsn}, 32'h7);
    fsrc <= 28'h0;
    nsrc <= 28'h0;
    tick(2);
    $display("unprioritised path done");
  endtask
  task automatic t_nested;
    wrc(32'hffff_0020, 32'h0003_0050, 32'h0003_0050);
    wrc(32'hffff_0030, 32'h0000_0002, 32'h0000_0002);
    fsrc <= 28'h000_0012;
    tick(2);
    check({27'h0, fsn}, 32'h4);
    wrc(32'hffff_0030, 32'h0000_0001, 32'h0000_0001);
    tick(1);
    check({27'h0, fsn}, 32'h1);
    fsrc <= 28'h0;
    nsrc <= 28'h000_0012;
    tick(2);
    i_vnip_core_model.take_irq(d);
    check(d, 32'h0009_1a10);
    i_vnip_core_model.bus_rd(32'hffff_003c, d);
    check(d, 32'h0000_0008);
    tick(1);
    check({31'h0, nreq}, 32'h0);
    nsrc <= 28'h000_0013;
    tick(2);
    check({31'h0, nreq}, 32'h1);
    i_vnip_core_model.take_irq(d);
    check(d, 32'h0009_1a00);
    i_vnip_core_model.bus_rd(32'hffff_003c, d);
    check(d, 32'h0000_0009);
    wrc(32'hffff_003c, 32'h0000_00fe, 32'h0000_0009);
    wrc(32'hffff_003c, 32'h0000_00ff, 32'h0000_0008);
    wrc(32'hffff_003c, 32'h0000_00ff, 32'h0000_0000);
    nsrc <= 28'h0;
    tick(2);
    $display("nesting done");
  endtask
  task automatic t_events;
    wrc(32'hffff_0048, 32'h0000_0003, 32'h0000_0000);
    i_vnip_core_model.bus_rd(32'hffff_0044, d);
    check(d, 32'h0000_0000);
    wrc(32'hffff_004c, 32'h0000_0003, 32'h0000_0003);
    nsrc <= 28'h000_0001;
    tick(3);
    i_vnip_core_model.bus_rd(32'hffff_0044, d);
    check(d, 32'h0000_0001);
    check({31'h0, eirq}, 32'h1);
    wrc(32'hffff_004c, 32'h0000_0002, 32'h0000_0002);
    check({31'h0, eirq}, 32'h0);
    wrc(32'hffff_004c, 32'h0000_0001, 32'h0000_0001);
    check({31'h0, eirq}, 32'h1);
    wrc(32'hffff_0048, 32'h0000_0001, 32'h0000_0000);
    i_vnip_core_model.bus_rd(32'hffff_0044, d);
    check(d, 32'h0000_0000);
    check({31'h0, eirq}, 32'h0);
    nsrc <= 28'h0;
    $display("events done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    tick(20000);
    errors++;
    print_verdict();
  end
  initial begin
    errors = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    nsrc = 28'h0;
    fsrc = 28'h0;
    tick(12);
    rst_n <= 1'b1;
    tick(3);
    t_reset();
    t_masks();
    t_plain();
    t_nested();
    t_events();
    print_verdict();
  end
endmodule

// ---- vnip_irq_priority_properties.sv ----
`timescale 1ns/10ps
module vnip_irq_priority_properties #(
  parameter int NUM_SRC = vnip_pkg::NUM_SRC
) (
  input  wire logic                        ref_clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic [31:0]                 avs_address_in,
  input  wire logic                        avs_read_in,
  input  wire logic                        avs_write_in,
  input  wire logic [3:0]                  avs_byteenable_in,
  input  wire logic [31:0]                 avs_writedata_in,
  input  wire logic [31:0]                 avs_readdata_out,
  input  wire logic                        avs_waitrequest_out,
  input  wire logic [NUM_SRC-1:0]          normal_src_in,
  input  wire logic [NUM_SRC-1:0]          fast_src_in,
  input  wire logic                        normal_req_out,
  input  wire logic                        fast_req_out,
  input  wire logic [vnip_pkg::SRC_W-1:0]  fast_source_out,
  input  wire logic                        event_irq_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic rd_acc;
  assign rd_acc = avs_read_in && avs_waitrequest_out;
  property p_answer; (avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out ##1 avs_waitrequest_out; endproperty
  a_answer: assert property (p_answer) else $error("bus answer not one cycle");
  property p_vec_frame; rd_acc && avs_address_in == vnip_pkg::ADDR_IRQ_VECTOR
    |=> avs_readdata_out[31:23] == 9'h0 && avs_readdata_out[1:0] == 2'h0; endproperty
  a_vec_frame: assert property (p_vec_frame) else $error("vector frame bits set");
  property p_vec_src; rd_acc && avs_address_in == vnip_pkg::ADDR_IRQ_VECTOR
    |=> avs_readdata_out[6:2] <= 5'd27; endproperty
  a_vec_src: assert property (p_vec_src) else $error("vector source out of range");
  property p_prio0; rd_acc && avs_address_in == vnip_pkg::ADDR_PRIO_TIMERS
    |=> (avs_readdata_out & 32'h8888_888f) == 32'h0; endproperty
  a_prio0: assert property (p_prio0) else $error("timer priority spare bits");
  property p_prio1; rd_acc && avs_address_in == vnip_pkg::ADDR_PRIO_SERIAL
    |=> (avs_readdata_out & 32'h8888_8888) == 32'h0; endproperty
  a_prio1: assert property (p_prio1) else $error("serial priority spare bits");
  property p_prio2; rd_acc && avs_address_in == vnip_pkg::ADDR_PRIO_EXTERNAL
    |=> (avs_readdata_out & 32'h8888_8888) == 32'h0; endproperty
  a_prio2: assert property (p_prio2) else $error("external priority spare bits");
  property p_prio3; rd_acc && avs_address_in == vnip_pkg::ADDR_PRIO_PWM
    |=> (avs_readdata_out & 32'hffff_ff88) == 32'h0; endproperty
  a_prio3: assert property (p_prio3) else $error("pwm priority spare bits");
  property p_fast_wins; fast_req_out |-> !normal_req_out; endproperty
  a_fast_wins: assert property (p_fast_wins) else $error("normal beside fast");
  property p_fast_req; |fast_src_in |=> fast_req_out; endproperty
  a_fast_req: assert property (p_fast_req) else $error("fast request missing");
  property p_norm_quiet; !(|normal_src_in) |=> !normal_req_out; endproperty
  a_norm_quiet: assert property (p_norm_quiet) else $error("normal without source");
endmodule
bind vnip_irq_priority vnip_irq_priority_properties #(.NUM_SRC(NUM_SRC)) i_props (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_byteenable_in(avs_byteenable_in),
  .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .normal_src_in(normal_src_in),
  .fast_src_in(fast_src_in), .normal_req_out(normal_req_out), .fast_req_out(fast_req_out),
  .fast_source_out(fast_source_out), .event_irq_out(event_irq_out));

// ---- vnip_pkg.sv ----
package vnip_pkg;

  // Source and level geometry
  localparam int NUM_SRC   = 28;
  localparam int SRC_W     = 5;
  localparam int LEVEL_W   = 3;
  localparam int NUM_LEVEL = 8;
  localparam int PRIO_REGS = 4;
  localparam int FIELD_PITCH = 4;

  // Register byte addresses
  localparam logic [31:0] ADDR_IRQ_VECTOR       = 32'hffff_001c;
  localparam logic [31:0] ADDR_PRIO_TIMERS      = 32'hffff_0020;
  localparam logic [31:0] ADDR_PRIO_SERIAL      = 32'hffff_0024;
  localparam logic [31:0] ADDR_PRIO_EXTERNAL    = 32'hffff_0028;
  localparam logic [31:0] ADDR_PRIO_PWM         = 32'hffff_002c;
  localparam logic [31:0] ADDR_NESTING_CONTROL  = 32'hffff_0030;
  localparam logic [31:0] ADDR_NORMAL_IN_SERVICE = 32'hffff_003c;
  localparam logic [31:0] ADDR_VECTOR_BASE      = 32'hffff_0040;
  localparam logic [31:0] ADDR_EVENT_STATUS     = 32'hffff_0044;
  localparam logic [31:0] ADDR_EVENT_CLEAR      = 32'hffff_0048;
  localparam logic [31:0] ADDR_EVENT_ENABLE     = 32'hffff_004c;

  // Writable bits of each priority register
  localparam logic [31:0] PRIO_MASK_TIMERS   = 32'h7777_7770;
  localparam logic [31:0] PRIO_MASK_SERIAL   = 32'h7777_7777;
  localparam logic [31:0] PRIO_MASK_EXTERNAL = 32'h7777_7777;
  localparam logic [31:0] PRIO_MASK_PWM      = 32'h0000_0077;

  // Vector word layout
  localparam int VEC_SRC_LSB  = 2;
  localparam int VEC_BASE_LSB = 7;
  localparam int BASE_W       = 16;

  // Nesting control bits
  localparam int NEST_NORMAL_BIT = 0;
  localparam int NEST_FAST_BIT   = 1;
  localparam int NEST_W          = 2;

  // Event status bits
  localparam int EV_NORMAL_BIT = 0;
  localparam int EV_FAST_BIT   = 1;
  localparam int EV_W          = 2;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0]  RST_BYTE = 8'h00;

  typedef struct packed {
    logic                found;
    logic [SRC_W-1:0]    num;
    logic [LEVEL_W-1:0]  level;
  } vnip_pick_t;

endpackage
